//--- logic/sld_pkg.sv
// Package of widths, depths and reset values for the latched sink driver
package sld_pkg;
	// Width of the shift register, the storage register and the drain bank
	localparam int unsigned CHAN_W     = 8;
	// Number of words the latch FIFO holds
	localparam int unsigned FIFO_DEPTH = 16;
	// Reset value of the shift, storage and drain registers
	localparam logic [CHAN_W-1:0] CHAN_ZERO = 8'h00;
	// Reset value of a single synchroniser or edge flop
	localparam logic BIT_ZERO = 1'h0;
	// Reset value of the active-low pins while held in reset (inactive level)
	localparam logic BIT_ONE  = 1'h1;
	// Index of the last shift stage, which feeds the serial output
	localparam int unsigned LAST_STAGE = CHAN_W - 1;
endpackage

//--- logic/sld_driver.sv
// Latched sink driver: pin synchronisers, shift and storage registers, latch FIFO
//
// Function
// - 8-bit shift register feeds 8-bit storage register.
// - Shift on shift clock rise, latch on latch rise.
// - Storage reaches output buffer only while clear high.
// - Clear low zeroes the shift and storage registers and empties the latch FIFO.
// - Enable high forces every drain off.
// - Enable low makes drains follow storage register.
// - Buffer bit zero off, one sinks current.
// - Serial output carries shift data for daisy chain.
// - Enabled outputs: one switches load on, zero off.
`timescale 1ns/1ps
`default_nettype none

// Synchronous FIFO with valid and ready on both sides
module sld_fifo #(
	parameter int unsigned WIDTH = 8,
	parameter int unsigned DEPTH = 16
) (
	// Clock and reset
	input  wire logic             clk_i,
	input  wire logic             rst_i,
	input  wire logic             flush_i,
	// Filling side
	input  wire logic             in_valid_i,
	output var  logic             in_ready_o,
	input  wire logic [WIDTH-1:0] in_data_i,
	// Draining side
	output var  logic             out_valid_o,
	input  wire logic             out_ready_i,
	output var  logic [WIDTH-1:0] out_data_o
);
	localparam int unsigned AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_q [DEPTH];  // Word storage
	logic [AW:0]      wr_q, wr_d;     // Write pointer with wrap bit
	logic [AW:0]      rd_q, rd_d;     // Read pointer with wrap bit
	logic             push, pop;      // Accepted transfers
	logic             full, empty;    // Honest occupancy flags

	// Occupancy from the pointers
	always_comb begin
		empty       = (wr_q == rd_q);
		full        = (wr_q[AW-1:0] == rd_q[AW-1:0]) && (wr_q[AW] != rd_q[AW]);
		in_ready_o  = !full;
		out_valid_o = !empty;
		out_data_o  = mem_q[rd_q[AW-1:0]];
		push        = in_valid_i && !full;
		pop         = out_ready_i && !empty;
		wr_d        = wr_q;
		rd_d        = rd_q;
		if (flush_i) begin
			// Flush empties the queue at once
			wr_d = '0;
			rd_d = '0;
		end else begin
			if (push) begin
				wr_d = wr_q + 1'b1;
			end
			if (pop) begin
				rd_d = rd_q + 1'b1;
			end
		end
	end

	// Pointer registers
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wr_q <= '0;
			rd_q <= '0;
		end else begin
			wr_q <= wr_d;
			rd_q <= rd_d;
		end
	end

	// Word storage needs no reset; pointers say what is valid
	always_ff @(posedge clk_i) begin
		if (push && !flush_i) begin
			mem_q[wr_q[AW-1:0]] <= in_data_i;
		end
	end
endmodule

// Top: the device logic behind its pins
module sld_driver (
	// System clock and reset
	input  wire logic                      CLOCK_I,
	input  wire logic                      SRST_I,
	// Serial link pins from the host, asynchronous to CLOCK_I
	input  wire logic                      SHIFT_CLOCK_I,
	input  wire logic                      LATCH_CLOCK_I,
	input  wire logic                      SERIAL_IN_I,
	input  wire logic                      CLEAR_N_I,
	input  wire logic                      OUTPUT_EN_N_I,
	// Serial output toward the next device in the chain
	output var  logic                      SERIAL_OUT_O,
	// Drain outputs, one per channel, high while sinking
	output var  logic [sld_pkg::CHAN_W-1:0] DRAIN_ON_O,
	// Latch FIFO flow control, on CLOCK_I
	input  wire logic                      UPDATE_HOLD_I,
	output var  logic                      LATCH_READY_O
);
	// Two-flop synchronisers, one row per pin
	logic [4:0] sync1_q, sync1_d;   // First stage, read only by the second
	logic [4:0] sync2_q, sync2_d;   // Second stage, usable level
	logic       sclk_prev_q, sclk_prev_d;   // Last shift clock level
	logic       lclk_prev_q, lclk_prev_d;   // Last latch clock level

	// Named views of the synchronised pins
	logic sclk_s, lclk_s, sdin_s, clear_n_s, oe_n_s;
	logic shift_rise, latch_rise;   // One-cycle edge enables

	// Shift and storage registers
	logic [sld_pkg::CHAN_W-1:0] shift_q, shift_d;
	logic [sld_pkg::CHAN_W-1:0] store_q, store_d;
	logic [sld_pkg::CHAN_W-1:0] drain_q, drain_d;
	logic [sld_pkg::CHAN_W-1:0] gate;   // Per-channel output buffer level
	logic                       sout_q, sout_d;
	logic                       lready_q, lready_d;

	// FIFO wiring
	logic                       fifo_in_ready;
	logic                       fifo_out_valid;
	logic [sld_pkg::CHAN_W-1:0] fifo_out_data;
	logic                       fifo_pop_ready;
	logic                       fifo_flush;

	// Synchroniser next values
	always_comb begin
		sync1_d     = {OUTPUT_EN_N_I, CLEAR_N_I, SERIAL_IN_I, LATCH_CLOCK_I, SHIFT_CLOCK_I};
		sync2_d     = sync1_q;
		sclk_prev_d = sync2_q[0];
		lclk_prev_d = sync2_q[1];
	end

	// Synchroniser registers; active-low pins rest at their idle level
	always_ff @(posedge CLOCK_I) begin
		if (SRST_I) begin
			sync1_q     <= {sld_pkg::BIT_ONE, sld_pkg::BIT_ONE, sld_pkg::BIT_ZERO,
			                sld_pkg::BIT_ZERO, sld_pkg::BIT_ZERO};
			sync2_q     <= {sld_pkg::BIT_ONE, sld_pkg::BIT_ONE, sld_pkg::BIT_ZERO,
			                sld_pkg::BIT_ZERO, sld_pkg::BIT_ZERO};
			sclk_prev_q <= sld_pkg::BIT_ZERO;
			lclk_prev_q <= sld_pkg::BIT_ZERO;
		end else begin
			sync1_q     <= sync1_d;
			sync2_q     <= sync2_d;
			sclk_prev_q <= sclk_prev_d;
			lclk_prev_q <= lclk_prev_d;
		end
	end

	// Pin views and rising-edge enables from the second stage only
	always_comb begin
		sclk_s     = sync2_q[0];
		lclk_s     = sync2_q[1];
		sdin_s     = sync2_q[2];
		clear_n_s  = sync2_q[3];
		oe_n_s     = sync2_q[4];
		shift_rise = sclk_s && !sclk_prev_q;
		latch_rise = lclk_s && !lclk_prev_q;
	end

	// Latched words queue in the FIFO; clear empties it
	always_comb begin
		fifo_flush     = !clear_n_s;
		fifo_pop_ready = !UPDATE_HOLD_I;         // Storage may stall the drain side
	end

	sld_fifo #(
		.WIDTH (sld_pkg::CHAN_W),
		.DEPTH (sld_pkg::FIFO_DEPTH)
	) u_fifo (
		.clk_i       (CLOCK_I),
		.rst_i       (SRST_I),
		.flush_i     (fifo_flush),
		.in_valid_i  (latch_rise),
		.in_ready_o  (fifo_in_ready),
		.in_data_i   (shift_q),
		.out_valid_o (fifo_out_valid),
		.out_ready_i (fifo_pop_ready),
		.out_data_o  (fifo_out_data)
	);

	// Shift, storage and serial output next values
	always_comb begin
		shift_d  = shift_q;
		store_d  = store_q;
		lready_d = fifo_in_ready;
		if (!clear_n_s) begin
			// Clear holds the shift and storage registers at zero while low
			shift_d = sld_pkg::CHAN_ZERO;
			store_d = sld_pkg::CHAN_ZERO;
		end else begin
			if (shift_rise) begin
				// Serial input enters stage 0, each stage moves up one
				shift_d = {shift_q[sld_pkg::LAST_STAGE-1:0], sdin_s};
			end
			if (fifo_out_valid && fifo_pop_ready) begin
				// Latched word moves into the storage register
				store_d = fifo_out_data;
			end
		end
		// Last stage drives the chain output
		sout_d = shift_d[sld_pkg::LAST_STAGE];
	end

	// Per-channel output buffer gating
	generate
		for (genvar ch = 0; ch < sld_pkg::CHAN_W; ch++) begin : g_chan
			// Bit one sinks only with clear high and enable low
			assign gate[ch] = store_q[ch] && clear_n_s && !oe_n_s;
		end
	endgenerate

	// Drain next value follows the gated buffer
	always_comb begin
		drain_d = gate;
	end

	// Data path registers
	always_ff @(posedge CLOCK_I) begin
		if (SRST_I) begin
			shift_q  <= sld_pkg::CHAN_ZERO;
			store_q  <= sld_pkg::CHAN_ZERO;
			drain_q  <= sld_pkg::CHAN_ZERO;
			sout_q   <= sld_pkg::BIT_ZERO;
			lready_q <= sld_pkg::BIT_ZERO;
		end else begin
			shift_q  <= shift_d;
			store_q  <= store_d;
			drain_q  <= drain_d;
			sout_q   <= sout_d;
			lready_q <= lready_d;
		end
	end

	// Outputs straight from flops
	always_comb begin
		SERIAL_OUT_O  = sout_q;
		DRAIN_ON_O    = drain_q;
		LATCH_READY_O = lready_q;
	end
endmodule

`default_nettype wire

//--- tb/sld_driver_monitor.sv
// Checker of pin-to-output behaviour of the sink driver
`timescale 1ns/1ps
`default_nettype none
module sld_driver_monitor (
	// Clock, reset and host pins
	input wire logic                       CLOCK_I,
	input wire logic                       SRST_I,
	input wire logic                       SHIFT_CLOCK_I,
	input wire logic                       LATCH_CLOCK_I,
	input wire logic                       SERIAL_IN_I,
	input wire logic                       CLEAR_N_I,
	input wire logic                       OUTPUT_EN_N_I,
	input wire logic                       UPDATE_HOLD_I,
	// Device outputs
	input wire logic                       SERIAL_OUT_O,
	input wire logic [sld_pkg::CHAN_W-1:0] DRAIN_ON_O,
	input wire logic                       LATCH_READY_O
);
	logic [7:0] sh_q, sh_d;	// Shadow shift register
	logic [7:0] st_q, st_d;	// Shadow storage register
	logic       sck_q, lck_q;	// Pin levels one clock back
	default clocking @(posedge CLOCK_I); endclocking
	default disable iff (SRST_I);
	// Shadows step on pin edges; clear level zeroes them
	always_comb begin
		sh_d = (SHIFT_CLOCK_I && !sck_q) ? {sh_q[6:0], SERIAL_IN_I} : sh_q;
		// A latch refused by a full queue leaves storage alone
		st_d = (LATCH_CLOCK_I && !lck_q && LATCH_READY_O) ? sh_q : st_q;
		if (!CLEAR_N_I) begin
			{sh_d, st_d} = 16'h0000;
		end
	end
	// Register shadows and previous pin levels
	always_ff @(posedge CLOCK_I) begin
		if (SRST_I) begin
			{sck_q, lck_q, sh_q, st_q} <= 18'h00000;
		end else begin
			{sck_q, lck_q, sh_q, st_q} <= {SHIFT_CLOCK_I, LATCH_CLOCK_I, sh_d, st_d};
		end
	end
	property p_sout; (SHIFT_CLOCK_I == sck_q && CLEAR_N_I)[*5] |-> SERIAL_OUT_O == sh_q[7];
	endproperty
	a_sout: assert property (p_sout) else $error("serial out");
	property p_hold; (SHIFT_CLOCK_I == sck_q && CLEAR_N_I)[*5] |-> $stable(SERIAL_OUT_O);
	endproperty
	a_hold: assert property (p_hold) else $error("serial out moved");
	property p_drain; (!OUTPUT_EN_N_I && CLEAR_N_I && !UPDATE_HOLD_I && !LATCH_CLOCK_I)[*8]
		|-> DRAIN_ON_O == st_q; endproperty
	a_drain: assert property (p_drain) else $error("drains");
	property p_oe; OUTPUT_EN_N_I[*5] |-> DRAIN_ON_O == 8'h00; endproperty
	a_oe: assert property (p_oe) else $error("drains on");
	property p_clr; !CLEAR_N_I[*5] |-> DRAIN_ON_O == 8'h00; endproperty
	a_clr: assert property (p_clr) else $error("drains in clear");
	property p_clr_sh; !CLEAR_N_I[*5] |-> !SERIAL_OUT_O; endproperty
	a_clr_sh: assert property (p_clr_sh) else $error("shift in clear");
	property p_clr_now; $fell(CLEAR_N_I) |-> ##[2:5] (DRAIN_ON_O == 8'h00 && !SERIAL_OUT_O);
	endproperty
	a_clr_now: assert property (p_clr_now) else $error("clear late");
	property p_oe_now; $rose(OUTPUT_EN_N_I) |-> ##[2:5] DRAIN_ON_O == 8'h00; endproperty
	a_oe_now: assert property (p_oe_now) else $error("disable late");
	c_load: cover property ($rose(LATCH_CLOCK_I) ##8 DRAIN_ON_O != 8'h00);
	c_full: cover property (!LATCH_READY_O);
	c_sout: cover property ($rose(SERIAL_OUT_O));
endmodule
bind sld_driver sld_driver_monitor u_mon (.CLOCK_I(CLOCK_I), .SRST_I(SRST_I),
	.SHIFT_CLOCK_I(SHIFT_CLOCK_I), .LATCH_CLOCK_I(LATCH_CLOCK_I), .SERIAL_IN_I(SERIAL_IN_I),
	.CLEAR_N_I(CLEAR_N_I), .OUTPUT_EN_N_I(OUTPUT_EN_N_I), .UPDATE_HOLD_I(UPDATE_HOLD_I),
	.SERIAL_OUT_O(SERIAL_OUT_O), .DRAIN_ON_O(DRAIN_ON_O), .LATCH_READY_O(LATCH_READY_O));
`default_nettype wire

//--- tb/sld_host.sv
// Host model driving the sink driver's link pins
`timescale 1ns/1ps
`default_nettype none
module sld_host (
	// Bench clock that launches every pin change
	input  wire logic clk_i,
	// Link pins toward the device
	output var  logic sck_o,
	output var  logic lck_o,
	output var  logic sin_o,
	output var  logic clr_n_o,
	output var  logic oe_n_o
);
	// Half a link clock period in bench clocks: 6 x 4 ns, so a 48 ns period
	localparam int HALF = 6;
	// Clocks still low, clear and enable inactive
	initial {sck_o, lck_o, sin_o, clr_n_o, oe_n_o} = 5'h03;
	// Shift one byte, top bit first; data only moves while the clock is low
	task automatic shift8(input logic [7:0] w);
		@(posedge clk_i);
		for (int i = 7; i >= 0; i--) begin
			sin_o <= w[i];
			repeat (HALF) @(posedge clk_i);
			sck_o <= 1'h1;
			repeat (HALF) @(posedge clk_i);
			sck_o <= 1'h0;
		end
		sin_o <= !sin_o; // Data not held after the frame
	endtask
	// One latch pulse, low for half a period before it so pulses stay apart
	task automatic latch_pulse();
		repeat (HALF) @(posedge clk_i);
		lck_o <= 1'h1;
		repeat (HALF) @(posedge clk_i);
		lck_o <= 1'h0;
	endtask
	// Clear and enable levels; enable may be pulsed to dim
	task automatic levels(input logic clr_n, input logic oe_n);
		@(posedge clk_i);
		{clr_n_o, oe_n_o} <= {clr_n, oe_n};
	endtask
endmodule
`default_nettype wire

//--- tb/sld_driver_test.sv
// Self-checking bench of the latched sink driver
`timescale 1ns/1ps
`default_nettype none
module sld_driver_test;
	logic       clk = 1'h0;	// System clock
	logic       rst = 1'h1;	// Synchronous reset
	logic       hold = 1'h0;	// Storage update stall
	logic       sck, lck, sin, clr_n, oe_n;	// Host pins
	logic       sout, rdy;	// Serial out, latch ready
	logic [7:0] drain;	// Drain bank
	int         error_cnt = 0;	// Mismatches
	int         samples_checked = 0;	// Comparisons
	// 250 MHz clock
	always #2 clk = ~clk;
	sld_host u_host (.clk_i(clk), .sck_o(sck), .lck_o(lck), .sin_o(sin), .clr_n_o(clr_n),
		.oe_n_o(oe_n));
	sld_driver u_dut (.CLOCK_I(clk), .SRST_I(rst), .SHIFT_CLOCK_I(sck), .LATCH_CLOCK_I(lck),
		.SERIAL_IN_I(sin), .CLEAR_N_I(clr_n), .OUTPUT_EN_N_I(oe_n), .SERIAL_OUT_O(sout),
		.DRAIN_ON_O(drain), .UPDATE_HOLD_I(hold), .LATCH_READY_O(rdy));
	// Compare and count
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		samples_checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("BAD %0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// Compare one flag and count
	task automatic chk_bit(input logic got, input logic exp);
		samples_checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("BAD %0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// Let pin changes cross the synchronisers; look between clock edges
	task automatic settle();
		repeat (10) @(posedge clk);
		@(negedge clk);
	endtask
	// Two chained bytes, one latch
	task automatic t_chain();
		u_host.shift8(8'hc3);
		settle();
		chk_bit(sout, 1'h1);
		u_host.shift8(8'h5a);
		u_host.latch_pulse();
		u_host.levels(1'h1, 1'h0);
		settle();
		chk(drain, 8'h5a);
		chk_bit(sout, 1'h0);
	endtask
	// Enable pulsed like a dimming wave
	task automatic t_dim();
		for (int i = 0; i < 3; i++) begin
			u_host.levels(1'h1, 1'h1);
			settle();
			chk(drain, 8'h00);
			u_host.levels(1'h1, 1'h0);
			settle();
			chk(drain, 8'h5a);
		end
	endtask
	// Clear mid-run; registers stay zero after
	task automatic t_clear();
		u_host.shift8(8'h81);
		settle();
		chk_bit(sout, 1'h1);
		u_host.levels(1'h0, 1'h0);
		settle();
		chk(drain, 8'h00);
		chk_bit(sout, 1'h0);
		u_host.levels(1'h1, 1'h0);
		settle();
		chk(drain, 8'h00);
	endtask
	// Stalled storage: 16 latches fill the queue, a 17th word is refused
	task automatic t_fifo();
		u_host.levels(1'h1, 1'h1);
		u_host.shift8(8'h3c);
		@(posedge clk) hold <= 1'h1;
		repeat (16) u_host.latch_pulse();
		u_host.shift8(8'hc5);
		u_host.latch_pulse();
		settle();
		chk_bit(rdy, 1'h0);
		@(posedge clk) hold <= 1'h0;
		repeat (4) settle();
		chk_bit(rdy, 1'h1);
		u_host.levels(1'h1, 1'h0);
		settle();
		chk(drain, 8'h3c);
		chk_bit(sout, 1'h1);
	endtask
	// Counts and verdict
	task automatic complete_run();
		$display("errors %0d checks %0d", error_cnt, samples_checked);
		if (error_cnt == 0 && samples_checked > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	// Reset, start-up clear, scenarios
	initial begin
		repeat (5) @(posedge clk);
		rst <= 1'h0;
		settle();
		u_host.levels(1'h0, 1'h1);
		settle();
		u_host.levels(1'h1, 1'h1);
		t_chain();
		t_dim();
		t_clear();
		t_fifo();
		complete_run();
	end
	// Watchdog
	initial begin
		#50us;
		error_cnt++;
		complete_run();
	end
endmodule
`default_nettype wire
